// ### hw/fct_pkg.sv
// shared constants and types of the fixed-cycle timer block
package fct_pkg;
  // clock period of pclk in ns
  localparam int CLK_NS = 20;
  // auto-release time of the interrupt pin for the fastest tick, in ns
  localparam int REL_FAST_NS = 122_000;
  // auto-release time for the three slower ticks, in ns
  localparam int REL_SLOW_NS = 7_812_500;
  // both times round down to whole cycles
  localparam int REL_FAST_CYC = REL_FAST_NS / CLK_NS;
  localparam int REL_SLOW_CYC = REL_SLOW_NS / CLK_NS;
  // default counter width
  localparam int PRESET_W = 12;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESET = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  // field positions in the flag register
  localparam int FLAG_TF_BIT = 0;
  localparam int FLAG_LOW_BIT = 1;
  localparam int FLAG_PIN_BIT = 2;
  // field positions in the interrupt status, clear and enable registers
  localparam int IRQ_EVT_BIT = 0;
  localparam int IRQ_REL_BIT = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [11:0] PRESET_RST = 12'h001;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  // tick source codes
  localparam logic [1:0] TSEL_4096HZ = 2'h0;
  // control register layout, bit 0 upward: run, tick select, irq enable
  typedef struct packed {
    logic timer_irq_enable;
    logic [1:0] tick_source_select;
    logic timer_run;
  } ctrl_s;
  // pins from outside the pclk domain
  typedef struct packed {
    logic int_pin;
    logic scl;
    logic [3:0] tick;
  } pins_s;
  // countdown states
  typedef enum {ST_IDLE, ST_ARMED, ST_COUNT} tmr_state_e;
endpackage

// ### hw/fixed_cycle_timer_irq.sv
// fixed-cycle countdown timer with open-drain interrupt pin and apb registers

// Summary of operation
// - run bit 0 stops, 1 runs timer
// - each run rise restarts from preset value
// - event sets flag, held until zero written
// - clearing flag never releases a low pin
// - writing one to flag does nothing
// - event with irq enable drives pin low
// - enable off blocks and releases timer low
// - other sources still drive pin low
// - timer low auto-releases within about 7.8 ms
// - period equals tick period times preset
// - first period up to one tick short
// - countdown starts at serial clock rising edge
// - two-bit select picks one of four ticks
// - event on 001h to 000h, then reload
// - release 122 us fast, 7.8125 ms otherwise
module fixed_cycle_timer_irq #(
  parameter int PRESET_W = fct_pkg::PRESET_W, // counter width
  parameter int REL_FAST_CYC = fct_pkg::REL_FAST_CYC, // release cycles, fast tick
  parameter int REL_SLOW_CYC = fct_pkg::REL_SLOW_CYC // release cycles, slow ticks
) (
  input wire logic pclk, // bus clock, 50 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 = write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic scl_in, // serial bus clock pin
  input wire logic [3:0] tick_in, // tick sources: 4096 Hz, 64 Hz, 1 Hz, minute
  input wire logic ext_irq_req, // other interrupt sources, same clock
  input wire logic int_pin_in, // level seen on the interrupt pin
  output logic int_pin_out, // interrupt pin drive value, always low
  output logic int_pin_oe, // interrupt pin enable, high while pulling low
  output logic irq // level interrupt to the local cpu
);
  import fct_pkg::*;

  localparam int REL_W = $clog2(REL_SLOW_CYC + 1); // release counter width

  // refuse settings the counters cannot hold
  if (PRESET_W < 1 || PRESET_W > 31) begin : g_chk_w
    $error("preset width out of range");
  end
  if (REL_FAST_CYC < 1 || REL_FAST_CYC > REL_SLOW_CYC) begin : g_chk_rel
    $error("release cycle counts out of range");
  end

  pins_s pins_now; // raw pins
  pins_s sync1; // first stage, read only by sync2
  pins_s sync2; // second stage
  pins_s sync3; // third stage
  pins_s stab; // debounced level
  pins_s stab_q; // previous debounced level
  pins_s rise; // one-cycle rising edges

  ctrl_s ctrl; // control register
  logic [PRESET_W-1:0] preset; // countdown preset
  logic [PRESET_W-1:0] count; // live countdown value
  tmr_state_e state; // countdown state
  logic timer_event_flag; // sticky event flag
  logic int_low; // timer holds the pin low
  logic [REL_W-1:0] rel_cnt; // cycles left until auto-release
  logic [IRQ_W-1:0] irq_stat; // sticky interrupt status
  logic [IRQ_W-1:0] irq_en; // interrupt enable
  logic [31:0] rd_data; // read mux
  logic addr_ok; // address is mapped

  logic setup; // apb setup cycle
  logic wr_en; // apb write completes this edge
  logic wr_ctrl; // write to control
  logic stop_wr; // write clears run
  logic run_rise; // write sets run from 0
  logic ie_off_wr; // write clears irq enable
  logic flag_clr; // write 0 to event flag
  logic sel_tick; // selected tick edge
  logic tmr_event; // count steps 001h to 000h
  logic rel_done; // auto-release expires
  logic [IRQ_W-1:0] irq_set; // interrupt events this cycle

  assign pins_now = '{int_pin: int_pin_in, scl: scl_in, tick: tick_in};

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      stab <= '0;
      stab_q <= '0;
    end else begin
      sync1 <= pins_now;
      sync2 <= sync1;
      sync3 <= sync2;
      stab <= (sync2 & sync3) | (stab & (sync2 | sync3));
      stab_q <= stab;
    end
  end

  assign rise = stab & ~stab_q;
  // pick the tick source
  assign sel_tick = rise.tick[ctrl.tick_source_select];

  // bus decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign wr_ctrl = wr_en && (paddr == ADDR_CTRL);
  assign stop_wr = wr_ctrl && !pwdata[0];
  assign run_rise = wr_ctrl && pwdata[0] && !ctrl.timer_run;
  assign ie_off_wr = wr_ctrl && !pwdata[3];
  // only a 0 clears; a 1 is ignored
  assign flag_clr = wr_en && (paddr == ADDR_FLAG) && !pwdata[FLAG_TF_BIT];

  // event only from a running countdown at 001h; a stopping write masks it
  assign tmr_event = (state == ST_COUNT) && sel_tick && (count == PRESET_W'(1)) && !stop_wr;
  assign rel_done = int_low && (rel_cnt == REL_W'(1)) && !stop_wr && !ie_off_wr;
  assign irq_set = {rel_done, tmr_event};

  // read mux and address check
  always_comb begin
    rd_data = '0;
    addr_ok = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rd_data[3:0] = ctrl;
    end else if (paddr == ADDR_PRESET) begin
      rd_data[PRESET_W-1:0] = preset;
    end else if (paddr == ADDR_FLAG) begin
      rd_data[FLAG_TF_BIT] = timer_event_flag;
      rd_data[FLAG_LOW_BIT] = int_low;
      rd_data[FLAG_PIN_BIT] = stab.int_pin;
    end else if (paddr == ADDR_COUNT) begin
      rd_data[PRESET_W-1:0] = count;
    end else if (paddr == ADDR_IRQ_STAT) begin
      rd_data[IRQ_W-1:0] = irq_stat;
    end else if (paddr == ADDR_IRQ_CLR) begin
      rd_data = '0; // write-only, reads zero
    end else if (paddr == ADDR_IRQ_EN) begin
      rd_data[IRQ_W-1:0] = irq_en;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // apb answer: ready in the first access cycle, data and error alongside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      prdata <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // control and preset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_s'(CTRL_RST);
      preset <= PRESET_W'(PRESET_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_s'(pwdata[3:0]);
      end
      // preset written while running only spoils the first period
      if (wr_en && (paddr == ADDR_PRESET)) begin
        preset <= pwdata[PRESET_W-1:0];
      end
    end
  end

  // countdown: armed by the run write, counting from the next scl rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      count <= '0;
    end else if (stop_wr) begin
      state <= ST_IDLE;
    end else if (run_rise) begin
      count <= preset;
      state <= ST_ARMED;
    end else begin
      case (state)
        ST_ARMED: begin
          // start phase is free against the tick, so first period may be short
          if (rise.scl) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (sel_tick) begin
            // one count per tick; a preset of 0 just reloads without event
            if (count <= PRESET_W'(1)) begin
              count <= preset;
            end else begin
              count <= count - PRESET_W'(1);
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky event flag, a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_event_flag <= 1'b0;
    end else if (tmr_event) begin
      timer_event_flag <= 1'b1;
    end else if (flag_clr) begin
      timer_event_flag <= 1'b0;
    end
  end

  // timer low level on the pin with auto-release; flag writes leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_low <= 1'b0;
      rel_cnt <= '0;
    end else if (stop_wr || ie_off_wr) begin
      int_low <= 1'b0;
      rel_cnt <= '0;
    end else if (tmr_event && ctrl.timer_irq_enable) begin
      int_low <= 1'b1;
      // release time follows the tick source
      if (ctrl.tick_source_select == TSEL_4096HZ) begin
        rel_cnt <= REL_W'(REL_FAST_CYC);
      end else begin
        rel_cnt <= REL_W'(REL_SLOW_CYC);
      end
    end else if (int_low) begin
      if (rel_done) begin
        int_low <= 1'b0;
      end
      rel_cnt <= rel_cnt - REL_W'(1);
    end
  end

  // open-drain pin: any enabled source pulls low, output value stays 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pin_oe <= 1'b0;
      int_pin_out <= 1'b0;
    end else begin
      int_pin_oe <= int_low || ext_irq_req;
      int_pin_out <= 1'b0;
    end
  end

  // local interrupt: sticky status, write-1 clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_en <= IRQ_EN_RST;
      irq <= 1'b0;
    end else begin
      if (wr_en && (paddr == ADDR_IRQ_CLR)) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      if (wr_en && (paddr == ADDR_IRQ_EN)) begin
        irq_en <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // checks on the countdown and the pin
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_stopped_idle: assert property (
    !ctrl.timer_run |-> (state == ST_IDLE) && !int_low
  ) else $error("timer not idle while run is off");

  chk_start_preset: assert property (
    $rose(ctrl.timer_run) |-> (state == ST_ARMED) && (count == preset)
  ) else $error("countdown did not restart from preset");

  chk_flag_sticky: assert property (
    timer_event_flag && !flag_clr |=> timer_event_flag
  ) else $error("event flag dropped without a clear");

  chk_event_flag: assert property (
    tmr_event |=> timer_event_flag && (count == $past(preset))
  ) else $error("event did not set flag and reload");

  chk_clear_holds: assert property (
    int_low && flag_clr && !stop_wr && !ie_off_wr && (rel_cnt > REL_W'(1)) |=> int_low
  ) else $error("flag clear released the pin");

  chk_irq_drive: assert property (
    tmr_event && ctrl.timer_irq_enable && !ie_off_wr |=> int_low ##1 int_pin_oe
  ) else $error("enabled event did not pull pin low");

  chk_irq_masked: assert property (
    tmr_event && !ctrl.timer_irq_enable && !int_low |=> !int_low
  ) else $error("disabled event pulled pin low");

  chk_other_source: assert property (
    ext_irq_req |=> int_pin_oe
  ) else $error("other source did not reach pin");

  chk_release_time: assert property (
    int_low |-> rel_cnt <= REL_W'(REL_SLOW_CYC)
  ) else $error("release count above the longest time");

  chk_release_fast: assert property (
    $rose(int_low) && (ctrl.tick_source_select == TSEL_4096HZ)
      |-> rel_cnt == REL_W'(REL_FAST_CYC)
  ) else $error("fast tick release time wrong");

  chk_scl_start: assert property (
    (state == ST_ARMED) ##1 (state == ST_COUNT) |-> $past(rise.scl)
  ) else $error("countdown started without scl edge");

  chk_tick_step: assert property (
    (state == ST_COUNT) && !sel_tick && !stop_wr && !run_rise |=> count == $past(count)
  ) else $error("count moved without a tick");

  chk_flag_write_one: assert property (
    wr_en && (paddr == ADDR_FLAG) && pwdata[FLAG_TF_BIT] && !tmr_event
      |=> timer_event_flag == $past(timer_event_flag)
  ) else $error("writing one changed the event flag");

  chk_stop_release: assert property (
    stop_wr |=> !int_low && (state == ST_IDLE)
  ) else $error("stop write did not release the pin");

  chk_enable_release: assert property (
    ie_off_wr |=> !int_low
  ) else $error("enable clear did not release the pin");

endmodule

// ### testbench/host_link.sv
// host side model: serial clock bursts and pulled-up open-drain interrupt wire
module host_link (
  input wire logic go, // request one serial frame
  input wire logic oe, // device pulls the interrupt wire
  input wire logic drv, // device drive value
  output logic scl, // serial clock, idles high
  output logic int_level, // resolved interrupt wire level
  output logic [7:0] frames // count of frames sent
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: clock high, no frames yet
  initial begin
    scl = 1'b1;
    frames = 8'h0;
  end
  // nine clocks of 160 ns per frame, still between frames
  always begin
    @(posedge go);
    #37;
    repeat (9) begin
      scl = 1'b0;
      #80;
      scl = 1'b1;
      #80;
    end
    frames = frames + 8'h1;
  end
  // pull-up unless the device pulls low
  assign int_level = (oe && !drv) ? 1'b0 : 1'b1;
endmodule

// ### testbench/tb.sv
// self-checking bench of the fixed-cycle timer block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fct_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0; // bus inputs
  logic [7:0] paddr = 8'h0; // byte address
  logic [31:0] pwdata = 32'h0, prdata; // bus data
  logic pready, pslverr, int_pin_out, int_pin_oe, irq; // outputs
  logic [3:0] tick_in = 4'h0; // tick sources
  logic ext_irq_req = 0, go = 0, scl, int_level; // link side
  logic [7:0] frames; // frames done
  logic [11:0] p; // preset under test
  exp_s q[$], e; // expected bus results
  int fails = 0, num_checks = 0, cyc = 0, n, s;
  int seed = 32'h12eb;
  // clock of 20 ns
  always #10 pclk = ~pclk;
  fixed_cycle_timer_irq #(.REL_FAST_CYC(40), .REL_SLOW_CYC(200)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .tick_in(tick_in), .ext_irq_req(ext_irq_req), .int_pin_in(int_level),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .irq(irq));
  host_link host (.go(go), .oe(int_pin_oe), .drv(int_pin_out), .scl(scl),
    .int_level(int_level), .frames(frames));
  // verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one comparison
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one apb transfer, expectation noted first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
           input logic [31:0] m, input logic er);
    q.push_back('{x, m, er});
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // wait as long as the slave needs; only the hang guard ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, 32'h0, 32'h0, 0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(0, a, 32'h0, x, m, 0);
  endtask
  // one tick period on source i
  task tick(input int i);
    tick_in[i] <= 1;
    repeat (6) @(posedge pclk);
    tick_in[i] <= 0;
    repeat (6) @(posedge pclk);
  endtask
  // one serial frame, then time for the synchronizer
  task frame;
    n = frames;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    while (frames == n) @(posedge pclk);
    repeat (5) @(posedge pclk);
  endtask
  function automatic logic [31:0] cv(input logic ie, input logic [1:0] sl, input logic r);
    return {28'h0, ie, sl, r};
  endfunction
  // result watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (q.size() == 0) fails++;
      else begin
        e = q.pop_front();
        chk("prdata", e.d & e.m, prdata & e.m);
        chk("pslverr", {31'h0, e.e}, {31'h0, pslverr});
      end
    end
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    // reset values, unmapped and misaligned places
    rd(ADDR_CTRL, 32'h0, 32'hffff_ffff);
    rd(ADDR_PRESET, 32'h1, 32'hffff_ffff);
    rd(ADDR_FLAG, 32'h4, 32'hffff_ffff);
    rd(ADDR_IRQ_EN, 32'h0, 32'hffff_ffff);
    rd(ADDR_IRQ_CLR, 32'h0, 32'hffff_ffff);
    apb(0, 8'h1c, 32'h0, 32'h0, 32'hffff_ffff, 1);
    apb(1, 8'h02, 32'h1, 32'h0, 32'h0, 1);
    wr(ADDR_IRQ_EN, 32'h3);
    // every tick source with a random preset
    for (s = 0; s < 4; s++) begin
      p = 12'(1 + ($random(seed) & 3));
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_PRESET, {20'h0, p});
      wr(ADDR_CTRL, cv(1, s[1:0], 1));
      tick(s);
      rd(ADDR_COUNT, {20'h0, p}, 32'hfff);
      frame();
      tick((s + 1) % 4);
      rd(ADDR_COUNT, {20'h0, p}, 32'hfff);
      repeat (p - 1) tick(s);
      rd(ADDR_FLAG, 32'h4, 32'h7);
      tick(s);
      chk("oe", 32'h1, {31'h0, int_pin_oe});
      chk("irq", 32'h1, {31'h0, irq});
      rd(ADDR_COUNT, {20'h0, p}, 32'hfff);
      wr(ADDR_FLAG, 32'h1);
      rd(ADDR_FLAG, 32'h3, 32'h7);
      wr(ADDR_FLAG, 32'h0);
      rd(ADDR_FLAG, 32'h2, 32'h3);
      n = 0;
      while (int_pin_oe !== 1'b0 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      // about 22 of the fast 40 low cycles have gone by before the wait starts
      chk("release", 32'h1, {31'h0, (s == 0) ? (n > 14 && n < 26) : (n > 100 && n < 205)});
      rd(ADDR_IRQ_STAT, 32'h3, 32'h3);
      wr(ADDR_IRQ_CLR, 32'h3);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // enable off blocks the pin, status masked
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_PRESET, 32'h2);
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_CTRL, cv(0, 0, 1));
    frame();
    tick(0);
    tick(0);
    chk("oe", 32'h0, {31'h0, int_pin_oe});
    rd(ADDR_FLAG, 32'h1, 32'h3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    // enable removed while pin is low
    wr(ADDR_CTRL, cv(1, 0, 1));
    tick(0);
    tick(0);
    chk("oe", 32'h1, {31'h0, int_pin_oe});
    wr(ADDR_CTRL, cv(0, 0, 1));
    // pin enable follows the release one edge later
    @(posedge pclk);
    chk("oe", 32'h0, {31'h0, int_pin_oe});
    // stop while pin is low, then ticks do nothing
    wr(ADDR_CTRL, cv(1, 0, 1));
    tick(0);
    tick(0);
    wr(ADDR_FLAG, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    @(posedge pclk);
    chk("oe", 32'h0, {31'h0, int_pin_oe});
    tick(0);
    tick(0);
    rd(ADDR_FLAG, 32'h0, 32'h1);
    // restart begins from preset
    wr(ADDR_PRESET, 32'h3);
    wr(ADDR_CTRL, cv(0, 0, 1));
    frame();
    tick(0);
    rd(ADDR_COUNT, 32'h2, 32'hfff);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, cv(0, 0, 1));
    rd(ADDR_COUNT, 32'h3, 32'hfff);
    // other sources still pull the pin
    ext_irq_req <= 1;
    // let the low wire pass the pin synchroniser before reading it back
    repeat (6) @(posedge pclk);
    chk("oe", 32'h1, {31'h0, int_pin_oe});
    rd(ADDR_FLAG, 32'h0, 32'h4);
    ext_irq_req <= 0;
    repeat (3) @(posedge pclk);
    finish_test;
  end
endmodule
